// ==== hdl/pmt_defs.svh ====
// Constants for the privilege mode transition unit
`ifndef PMT_DEFS_SVH
`define PMT_DEFS_SVH
`define PMT_PSW_W       8
`define PMT_IPL_HI      2
`define PMT_IPL_LO      0
`define PMT_MODE_BIT    3
`define PMT_ZERO_REG    5'h1f
`define PMT_PSW_RESET   8'h00
`endif

// ==== hdl/pmt_pkg.sv ====
// Types for the privilege mode transition unit
package pmt_pkg;
  typedef enum logic [1:0] {
    PMT_KERNEL = 2'h0,
    PMT_EXEC   = 2'h1,
    PMT_SUPER  = 2'h2,
    PMT_USER   = 2'h3
  } pmt_mode_t;
  typedef enum logic [3:0] {
    PMT_OP_NONE, PMT_OP_CALL_USER, PMT_OP_CALL_SUPER, PMT_OP_CALL_EXEC,
    PMT_OP_CALL_KERNEL, PMT_OP_RETURN, PMT_OP_EXCEPTION, PMT_OP_INTERRUPT,
    PMT_OP_MCHECK, PMT_OP_SWAP_AST, PMT_OP_PRIV_WRITE, PMT_OP_HALT
  } pmt_op_t;
endpackage : pmt_pkg

// ==== hdl/pmt_core.sv ====
// Privilege mode transition control
`timescale 1ns/1ps
`default_nettype none
`include "pmt_defs.svh"
module pmt_core (
  input  wire logic                 i_clk,
  input  wire logic                 i_reset_n,
  input  wire pmt_pkg::pmt_op_t     i_op,
  input  wire logic [1:0]           i_target_mode,
  input  wire logic [2:0]           i_target_ipl,
  input  wire logic                 i_reserved_opcode,
  input  wire logic                 i_privileged_instr,
  input  wire logic [4:0]           i_reg_addr,
  input  wire logic [63:0]          i_reg_data,
  output logic [1:0]                o_mode,
  output logic [2:0]                o_ipl,
  output logic                      o_halted,
  output logic                      o_transition,
  output logic                      o_blocked,
  output logic                      o_illegal_operation_fault,
  output logic [63:0]               o_reg_read
);
  import pmt_pkg::*;

  // ----------------------------------------
  // Mode state
  // ----------------------------------------
  logic [1:0]  mode_q, mode_d;
  logic [2:0]  ipl_q, ipl_d;
  logic        halt_q, halt_d, trans_q, trans_d, blk_q, blk_d, fault_q, fault_d;
  logic [63:0] rd_q, rd_d;
  logic [1:0]  tgt;
  logic [`PMT_PSW_W-1:0] psw;

  // Status word: level in low bits, non-kernel flag at mode bit
  always_comb begin
    psw = `PMT_PSW_RESET;
    psw[`PMT_IPL_HI:`PMT_IPL_LO] = ipl_q;
    psw[`PMT_MODE_BIT] = (mode_q != PMT_KERNEL);
  end

  always_comb begin
    mode_d  = mode_q;
    ipl_d   = ipl_q;
    halt_d  = halt_q;
    trans_d = 1'b0;
    blk_d   = 1'b0;
    fault_d = 1'b0;
    tgt     = PMT_KERNEL;
    // Zero register never carries data
    rd_d    = (i_reg_addr == `PMT_ZERO_REG) ? 64'h0 : i_reg_data;
    if (i_reserved_opcode || (i_privileged_instr && mode_q == PMT_USER)) begin
      fault_d = 1'b1;
    end else if (!halt_q) begin
      unique case (i_op)
        PMT_OP_NONE: ;
        // Calls never lower privilege: min of current and target
        PMT_OP_CALL_USER, PMT_OP_CALL_SUPER, PMT_OP_CALL_EXEC, PMT_OP_CALL_KERNEL: begin
          tgt = (i_op == PMT_OP_CALL_USER)  ? PMT_USER :
                (i_op == PMT_OP_CALL_SUPER) ? PMT_SUPER :
                (i_op == PMT_OP_CALL_EXEC)  ? PMT_EXEC : PMT_KERNEL;
          if (tgt <= mode_q) begin
            mode_d  = tgt;
            trans_d = 1'b1;
          end else begin
            blk_d = 1'b1;
          end
        end
        PMT_OP_RETURN: begin
          if (i_target_mode >= mode_q) begin
            mode_d  = i_target_mode;
            ipl_d   = i_target_ipl;
            trans_d = (i_target_mode > mode_q) || (i_target_ipl < ipl_q);
          end else begin
            blk_d = 1'b1;
          end
        end
        PMT_OP_EXCEPTION, PMT_OP_INTERRUPT, PMT_OP_MCHECK, PMT_OP_SWAP_AST: begin
          mode_d  = PMT_KERNEL;
          trans_d = 1'b1;
        end
        PMT_OP_PRIV_WRITE: begin
          if (mode_q == PMT_KERNEL) begin
            ipl_d   = i_target_ipl;
            // Only a level change is a counted transition
            trans_d = (i_target_ipl != ipl_q);
          end else begin
            blk_d = 1'b1;
          end
        end
        PMT_OP_HALT: begin
          if (mode_q == PMT_KERNEL) begin
            halt_d  = 1'b1;
            trans_d = 1'b1;
          end else begin
            blk_d = 1'b1;
          end
        end
        default: blk_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      mode_q  <= PMT_KERNEL;
      ipl_q   <= 3'h0;
      halt_q  <= 1'b0;
      trans_q <= 1'b0;
      blk_q   <= 1'b0;
      fault_q <= 1'b0;
      rd_q    <= 64'h0;
    end else begin
      mode_q  <= mode_d;
      ipl_q   <= ipl_d;
      halt_q  <= halt_d;
      trans_q <= trans_d;
      blk_q   <= blk_d;
      fault_q <= fault_d;
      rd_q    <= rd_d;
    end
  end

  assign o_mode = mode_q;
  assign o_ipl = psw[`PMT_IPL_HI:`PMT_IPL_LO];
  assign o_halted = halt_q;
  assign o_transition = trans_q;
  assign o_blocked = blk_q;
  assign o_illegal_operation_fault = fault_q;
  assign o_reg_read = rd_q;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  logic ok;
  assign ok = !i_reserved_opcode && !i_privileged_instr && !halt_q;
  property p_kernel_entry;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && (i_op inside {PMT_OP_EXCEPTION, PMT_OP_INTERRUPT, PMT_OP_MCHECK, PMT_OP_SWAP_AST})
      |=> o_mode == PMT_KERNEL && o_transition;
  endproperty
  a_kernel_entry: assert property (p_kernel_entry) else $error("entry not kernel");
  property p_halt_kernel_only;
    @(posedge i_clk) disable iff (!i_reset_n)
      $rose(o_halted) |-> $past(mode_q) == PMT_KERNEL;
  endproperty
  a_halt_kernel_only: assert property (p_halt_kernel_only) else $error("halt outside kernel");
  property p_zero_reg;
    @(posedge i_clk) disable iff (!i_reset_n)
      i_reg_addr == `PMT_ZERO_REG |=> o_reg_read == 64'h0;
  endproperty
  a_zero_reg: assert property (p_zero_reg) else $error("r31 nonzero");
  property p_fault;
    @(posedge i_clk) disable iff (!i_reset_n)
      (i_reserved_opcode || (i_privileged_instr && mode_q == PMT_USER))
      |=> o_illegal_operation_fault && $stable(o_mode);
  endproperty
  a_fault: assert property (p_fault) else $error("missing fault");
  property p_call_user;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && i_op == PMT_OP_CALL_USER && mode_q == PMT_USER |=> o_mode == PMT_USER;
  endproperty
  a_call_user: assert property (p_call_user) else $error("user call left user");
  property p_call_kernel;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && i_op == PMT_OP_CALL_KERNEL |=> o_mode == PMT_KERNEL;
  endproperty
  a_call_kernel: assert property (p_call_kernel) else $error("kernel call failed");
  property p_super_return;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && i_op == PMT_OP_RETURN && mode_q == PMT_SUPER
      |=> o_mode inside {PMT_USER, PMT_SUPER};
  endproperty
  a_super_return: assert property (p_super_return) else $error("bad supervisor return");
  property p_blocked_keeps;
    @(posedge i_clk) disable iff (!i_reset_n)
      o_blocked |-> o_mode == $past(mode_q) && !o_transition;
  endproperty
  a_blocked_keeps: assert property (p_blocked_keeps) else $error("blocked changed mode");
  property p_return_count;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && i_op == PMT_OP_RETURN && i_target_mode == mode_q && i_target_ipl >= ipl_q
      |=> !o_transition;
  endproperty
  a_return_count: assert property (p_return_count) else $error("return miscounted");
  property p_psw_bits;
    @(posedge i_clk) disable iff (!i_reset_n)
      psw[`PMT_MODE_BIT] == (mode_q != PMT_KERNEL) && psw[2:0] == ipl_q;
  endproperty
  a_psw_bits: assert property (p_psw_bits) else $error("status layout");
  // Privileged code above user level must not fault
  property p_no_fault_above_user;
    @(posedge i_clk) disable iff (!i_reset_n)
      !i_reserved_opcode && i_privileged_instr && mode_q != PMT_USER
      |=> !o_illegal_operation_fault;
  endproperty
  a_no_fault_above_user: assert property (p_no_fault_above_user) else $error("spurious fault");
  property p_undefined_op;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && i_op > PMT_OP_HALT |=> o_blocked && !o_transition;
  endproperty
  a_undefined_op: assert property (p_undefined_op) else $error("undefined op taken");
  property p_priv_write_level;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && i_op == PMT_OP_PRIV_WRITE && mode_q == PMT_KERNEL
      |=> o_mode == PMT_KERNEL && o_ipl == $past(i_target_ipl);
  endproperty
  a_priv_write_level: assert property (p_priv_write_level) else $error("bad level write");
  property p_call_exec;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && i_op == PMT_OP_CALL_EXEC && mode_q != PMT_KERNEL |=> o_mode == PMT_EXEC;
  endproperty
  a_call_exec: assert property (p_call_exec) else $error("executive call failed");
  property p_exec_return;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && i_op == PMT_OP_RETURN && mode_q == PMT_EXEC |=> o_mode != PMT_KERNEL;
  endproperty
  a_exec_return: assert property (p_exec_return) else $error("executive return raised");
  property p_demote_counts;
    @(posedge i_clk) disable iff (!i_reset_n)
      ok && i_op == PMT_OP_RETURN && i_target_mode > mode_q |=> o_transition;
  endproperty
  a_demote_counts: assert property (p_demote_counts) else $error("demotion not counted");
  // Halt is sticky: later requests may not move the mode
  sequence s_halt_taken;
    ok && i_op == PMT_OP_HALT && mode_q == PMT_KERNEL;
  endsequence
  sequence s_halt_held;
    o_halted && o_mode == PMT_KERNEL ##1 o_halted && o_mode == PMT_KERNEL;
  endsequence
  property p_halt_sticky;
    @(posedge i_clk) disable iff (!i_reset_n)
      s_halt_taken |=> s_halt_held;
  endproperty
  a_halt_sticky: assert property (p_halt_sticky) else $error("halt not held");
endmodule : pmt_core
`default_nettype wire

// ==== verif/pmt_core_test.sv ====
// Self-checking bench for the privilege mode transition unit
`timescale 1ns/1ps
`default_nettype none
module pmt_core_test;
  import pmt_pkg::*;
  logic              i_clk = 1'b0;
  logic              i_reset_n = 1'b0;
  pmt_op_t           i_op = PMT_OP_NONE;
  logic [1:0]        i_target_mode = 2'h0;
  logic [2:0]        i_target_ipl = 3'h0;
  logic              i_reserved_opcode = 1'b0;
  logic              i_privileged_instr = 1'b0;
  logic [4:0]        i_reg_addr = 5'h00;
  logic [63:0]       i_reg_data = 64'h0;
  logic [1:0]        o_mode;
  logic [2:0]        o_ipl;
  logic              o_halted, o_transition, o_blocked, o_fault;
  logic [63:0]       o_reg_read;
  int                fail_count = 0;
  int                compares = 0;
  // Row: op, target mode, expected mode, flags (4 pulse, 2 refused, 1 check pulse)
  logic [15:0] rows [0:32] = '{16'h5335, 16'h1030, 16'h5331, 16'h5033, 16'ha033, 16'hb033,
    16'h2025, 16'h1023, 16'h5123, 16'h5221, 16'h3015, 16'h5225, 16'h3015, 16'h5335, 16'h3015,
    16'h2013, 16'h3010, 16'h4005, 16'h5115, 16'h5013, 16'h4005, 16'h5225, 16'h6005, 16'h5335,
    16'h7005, 16'h5225, 16'h8005, 16'h5115, 16'h9005, 16'h5001, 16'h4000, 16'ha001, 16'h1003};

  always #12.5 i_clk = ~i_clk;

  pmt_core DUT (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_op(i_op),
    .i_target_mode(i_target_mode), .i_target_ipl(i_target_ipl),
    .i_reserved_opcode(i_reserved_opcode), .i_privileged_instr(i_privileged_instr),
    .i_reg_addr(i_reg_addr), .i_reg_data(i_reg_data), .o_mode(o_mode), .o_ipl(o_ipl),
    .o_halted(o_halted), .o_transition(o_transition), .o_blocked(o_blocked),
    .o_illegal_operation_fault(o_fault), .o_reg_read(o_reg_read));

  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      fail_count++;
    end
  endtask : chk

  // One operation for one edge, then idle so it is not taken twice
  task step(input logic [3:0] op, input logic [1:0] tm, input logic [2:0] ipl,
            input logic rsv, input logic prv);
    @(posedge i_clk);
    i_op <= pmt_op_t'(op);
    i_target_mode <= tm;
    i_target_ipl <= ipl;
    i_reserved_opcode <= rsv;
    i_privileged_instr <= prv;
    @(posedge i_clk);
    i_op <= PMT_OP_NONE;
    i_reserved_opcode <= 1'b0;
    i_privileged_instr <= 1'b0;
    #1;
  endtask : step

  task summarize;
    $display("compares=%0d fail_count=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : summarize

  // Watchdog sized well above the roughly one hundred cycles the tests need
  initial begin
    repeat (2000) @(posedge i_clk);
    fail_count++;
    summarize();
  end

  initial begin
    repeat (6) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    chk(o_mode, 64'h0);
    chk(o_ipl, 64'h0);
    $display("reset test done");
    for (int r = 0; r < 33; r++) begin
      step(rows[r][15:12], rows[r][9:8], 3'h0, 1'b0, 1'b0);
      chk(o_mode, rows[r][5:4]);
      chk(o_blocked, rows[r][1]);
      if (rows[r][0]) chk(o_transition, rows[r][2]);
    end
    $display("table test done");
    step(4'ha, 2'h0, 3'h5, 1'b0, 1'b0);
    chk(o_ipl, 64'h5);
    chk(o_transition, 64'h1);
    step(4'h5, 2'h0, 3'h2, 1'b0, 1'b0);
    chk(o_ipl, 64'h2);
    chk(o_transition, 64'h1);
    $display("level test done");
    @(posedge i_clk);
    i_reg_addr <= 5'h1f;
    i_reg_data <= 64'hffff_ffff_ffff_ffff;
    step(4'h0, 2'h0, 3'h0, 1'b0, 1'b0);
    chk(o_reg_read, 64'h0);
    @(posedge i_clk);
    i_reg_addr <= 5'h1e;
    step(4'h0, 2'h0, 3'h0, 1'b0, 1'b0);
    chk(o_reg_read, 64'hffff_ffff_ffff_ffff);
    $display("zero register test done");
    step(4'h5, 2'h3, 3'h2, 1'b0, 1'b0);
    step(4'h4, 2'h0, 3'h2, 1'b1, 1'b0);
    chk(o_fault, 64'h1);
    chk(o_mode, 64'h3);
    step(4'h0, 2'h0, 3'h2, 1'b0, 1'b1);
    chk(o_fault, 64'h1);
    step(4'h2, 2'h0, 3'h2, 1'b0, 1'b0);
    step(4'h0, 2'h0, 3'h2, 1'b0, 1'b1);
    chk(o_fault, 64'h0);
    step(4'h4, 2'h0, 3'h2, 1'b0, 1'b0);
    step(4'h0, 2'h0, 3'h2, 1'b0, 1'b1);
    chk(o_fault, 64'h0);
    $display("fault test done");
    step(4'hf, 2'h0, 3'h2, 1'b0, 1'b0);
    chk(o_blocked, 64'h1);
    chk(o_mode, 64'h0);
    $display("undefined op test done");
    step(4'hb, 2'h0, 3'h2, 1'b0, 1'b0);
    chk(o_halted, 64'h1);
    step(4'h5, 2'h3, 3'h2, 1'b0, 1'b0);
    chk(o_mode, 64'h0);
    chk(o_halted, 64'h1);
    $display("halt test done");
    @(posedge i_clk);
    i_reset_n <= 1'b0;
    repeat (2) @(posedge i_clk);
    i_reset_n <= 1'b1;
    #1;
    chk(o_halted, 64'h0);
    chk(o_ipl, 64'h0);
    chk(o_mode, 64'h0);
    $display("second reset test done");
    summarize();
  end
endmodule : pmt_core_test
`default_nettype wire
